// File: hdl/bsp_pkg.sv
// Purpose: Shared constants for the eight-pin bidirectional port with segment takeover.
// Assumes: Classic Wishbone with 32-bit data, one register per aligned word.
// Notes: Offsets are byte addresses; all registers are eight bits wide in the low lane.
package bsp_pkg;
  localparam int unsigned BSP_AW = 5;
  localparam logic [4:0] BSP_OFF_PIN_LEVEL = 5'h00;
  localparam logic [4:0] BSP_OFF_OUT_LATCH = 5'h04;
  localparam logic [4:0] BSP_OFF_DIRECTION = 5'h08;
  localparam logic [4:0] BSP_OFF_SEG_EN = 5'h0c;
  localparam logic [4:0] BSP_OFF_PAD_CFG = 5'h10;
  localparam logic [7:0] BSP_RST_LATCH = 8'h00;
  localparam logic [7:0] BSP_RST_DIR = 8'hff;
  localparam logic [7:0] BSP_RST_SEG_EN = 8'h00;
  localparam logic [7:0] BSP_RST_PAD_CFG = 8'h00;
  localparam int unsigned BSP_PULLUP_BIT = 5;
  localparam logic [7:0] BSP_PAD_CFG_MASK = 8'he6;
  localparam logic [1:0] BSP_SYNC_RST = 2'h0;
  typedef enum logic [1:0] {
    BSP_BUS_IDLE = 2'b00,
    BSP_BUS_ACK = 2'b01
  } bsp_bus_state_t;
endpackage

// File: hdl/bsp_sync.sv
// Purpose: Two-flop synchroniser for one pin level.
// Assumes: Single clock, synchronous active-high reset.
// Notes: The first flop feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module bsp_sync
  import bsp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic [1:0] stage_r;

  // Shift the level through two flops to settle metastability.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stage_r <= BSP_SYNC_RST;
    end
    else
    begin
      stage_r <= {stage_r[0], d_i};
    end
  end

  assign q_o = stage_r[1];
endmodule
`default_nettype wire

// File: hdl/bsp_pad.sv
// Purpose: Per-pin driver selection between segment drive, output latch and input.
// Assumes: Pin 0 never has a segment function.
// Notes: Pull-up request is gated off whenever the pin drives.
`timescale 1ns/1ps
`default_nettype none
module bsp_pad
  import bsp_pkg::*;
#(
  parameter bit HAS_SEGMENT = 1'b1
)
(
  input wire logic dir_in_i,
  input wire logic latch_i,
  input wire logic seg_en_i,
  input wire logic seg_drive_i,
  input wire logic pullup_enable_i,
  output logic pad_o,
  output logic pad_oe_o,
  output logic pullup_o,
  output logic digital_ok_o
);
  logic seg_active;

  // Segment drive, when enabled, beats every other function of the pin.
  assign seg_active = HAS_SEGMENT && seg_en_i;
  assign digital_ok_o = !seg_active;
  assign pad_oe_o = seg_active || !dir_in_i;
  assign pad_o = seg_active ? seg_drive_i : latch_i;
  // A driving pin never keeps its weak pull-up; neither does a segment pin.
  assign pullup_o = pullup_enable_i && dir_in_i && !seg_active;
endmodule
`default_nettype wire

// File: hdl/bsp_port.sv
// Purpose: Eight-pin bidirectional port with direction, latch, segment takeover and pull-ups.
// Assumes: Classic Wishbone slave, 20 MHz clk_i, synchronous active-high rst_i.
// Notes: Pin inputs are synchronised before software sees them.
// Functional notes
// - Eight pins, each direction set independently.
// - Direction and latch registers, bit n is pin n.
// - Direction 0 drives latch; 1 reads pin.
// - Reset makes every pin an input.
// - Pin-value write loads latch too.
// - Pins 1-7 digital only when segment disabled.
// - Enabled segment overrides pin; fixed segment map.
// - Shared pull-up bit 5 gates all pull-ups.
// - Output direction forces pull-up off.
// - Reset clears the pull-up control.
// - Small variant: pull-up bit reads zero.
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module bsp_port
  import bsp_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter bit FULL_PACKAGE = 1'b1
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [BSP_AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  input wire logic [7:0] segment_drive_i,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] pullup_o,
  output logic [7:0] digital_ok_o
);
  initial
  begin
    if (WIDTH != 8)
    begin
      $error("bsp_port supports only an eight-pin port");
    end
  end

  bsp_bus_state_t bus_state_r;
  logic [7:0] output_latch_r;
  logic [7:0] direction_r;
  logic [7:0] seg_enable_r;
  logic [7:0] pad_cfg_r;
  logic [7:0] pin_sync;
  logic [7:0] pin_level;
  logic [7:0] seg_route;
  logic [31:0] dat_nxt;
  logic req;
  logic hit;
  logic wr;
  logic pullup_enable;

  // Decode one address into a hit flag; used for reads and for writes.
  function automatic logic bsp_mapped(input logic [BSP_AW-1:0] a);
    if (a == BSP_OFF_PIN_LEVEL)
      return 1'b1;
    else if (a == BSP_OFF_OUT_LATCH)
      return 1'b1;
    else if (a == BSP_OFF_DIRECTION)
      return 1'b1;
    else if (a == BSP_OFF_SEG_EN)
      return 1'b1;
    else if (a == BSP_OFF_PAD_CFG)
      return 1'b1;
    else
      return 1'b0;
  endfunction

  // A request is taken only while idle so that ack is a single-cycle pulse.
  assign req = cyc_i && stb_i && (bus_state_r == BSP_BUS_IDLE);
  assign hit = bsp_mapped(adr_i);
  // Writes land in the request cycle, one cycle before the master samples ack.
  assign wr = req && hit && we_i && sel_i[0];

  // Bus handshake: answer one cycle after the request, then drop for one cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_state_r <= BSP_BUS_IDLE;
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end
    else
    begin
      case (bus_state_r)
        BSP_BUS_IDLE:
        begin
          if (cyc_i && stb_i)
          begin
            bus_state_r <= BSP_BUS_ACK;
            ack_o <= hit;
            err_o <= !hit;
          end
          else
          begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
          end
        end
        default:
        begin
          bus_state_r <= BSP_BUS_IDLE;
          ack_o <= 1'b0;
          err_o <= 1'b0;
        end
      endcase
    end
  end

  // Output latch: written through either the latch or the pin-value address.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      output_latch_r <= BSP_RST_LATCH;
    end
    else if (wr && (adr_i == BSP_OFF_OUT_LATCH || adr_i == BSP_OFF_PIN_LEVEL))
    begin
      output_latch_r <= dat_i[7:0];
    end
  end

  // Direction register; every bit is its own pin, so no bit couples to another.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      direction_r <= BSP_RST_DIR;
    end
    else if (wr && adr_i == BSP_OFF_DIRECTION)
    begin
      direction_r <= dat_i[7:0];
    end
  end

  // Segment enables; bit 0 is stored but pin 0 has no segment to give it.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      seg_enable_r <= BSP_RST_SEG_EN;
    end
    else if (wr && adr_i == BSP_OFF_SEG_EN)
    begin
      seg_enable_r <= dat_i[7:0];
    end
  end

  // Pad configuration; only the documented bits are kept, the rest read zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pad_cfg_r <= BSP_RST_PAD_CFG;
    end
    else if (wr && adr_i == BSP_OFF_PAD_CFG)
    begin
      pad_cfg_r <= dat_i[7:0] & BSP_PAD_CFG_MASK;
    end
  end

  // The small package has no pull-up control, so the bit is tied off.
  assign pullup_enable = FULL_PACKAGE && pad_cfg_r[BSP_PULLUP_BIT];

  // Synchronise each input level before software can read it.
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_sync
      bsp_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pin_i[g]),
        .q_o(pin_sync[g])
      );
    end
  endgenerate

  // Input pins report their level; driven pins read back the latch.
  assign pin_level = (pin_sync & direction_r) | (output_latch_r & ~direction_r);

  // Segment map: enable bit k is segment 32+k; pins take 33,34,35,39,38,37,36.
  assign seg_route[0] = 1'b0;
  assign seg_route[1] = segment_drive_i[1];
  assign seg_route[2] = segment_drive_i[2];
  assign seg_route[3] = segment_drive_i[3];
  assign seg_route[4] = segment_drive_i[7];
  assign seg_route[5] = segment_drive_i[6];
  assign seg_route[6] = segment_drive_i[5];
  assign seg_route[7] = segment_drive_i[4];

  logic [7:0] seg_en_route;
  assign seg_en_route = {seg_enable_r[4], seg_enable_r[5], seg_enable_r[6], seg_enable_r[7],
                         seg_enable_r[3], seg_enable_r[2], seg_enable_r[1], 1'b0};

  // One pad cell per pin; pin 0 is built without segment capability.
  generate
    for (g = 0; g < 8; g++)
    begin : g_pad
      bsp_pad #(
        .HAS_SEGMENT(g != 0)
      ) u_pad (
        .dir_in_i(direction_r[g]),
        .latch_i(output_latch_r[g]),
        .seg_en_i(seg_en_route[g]),
        .seg_drive_i(seg_route[g]),
        .pullup_enable_i(pullup_enable),
        .pad_o(pin_o[g]),
        .pad_oe_o(pin_oe_o[g]),
        .pullup_o(pullup_o[g]),
        .digital_ok_o(digital_ok_o[g])
      );
    end
  endgenerate

  // Read mux; unmapped addresses read zero and get err instead of ack.
  always_comb
  begin
    dat_nxt = 32'h0000_0000;
    if (adr_i == BSP_OFF_PIN_LEVEL)
      dat_nxt[7:0] = pin_level;
    else if (adr_i == BSP_OFF_OUT_LATCH)
      dat_nxt[7:0] = output_latch_r;
    else if (adr_i == BSP_OFF_DIRECTION)
      dat_nxt[7:0] = direction_r;
    else if (adr_i == BSP_OFF_SEG_EN)
      dat_nxt[7:0] = seg_enable_r;
    else if (adr_i == BSP_OFF_PAD_CFG)
    begin
      dat_nxt[7:0] = pad_cfg_r;
      dat_nxt[BSP_PULLUP_BIT] = pullup_enable;
    end
  end

  // Read data is registered together with ack.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_o <= 32'h0000_0000;
    end
    else if (req && !we_i)
    begin
      dat_o <= dat_nxt;
    end
  end
endmodule
`default_nettype wire

// File: testbench/bsp_pins_model.sv
// Purpose: Board side of the eight port pins.
// Assumes: An external source may drive every pin that the port leaves free.
// Notes: A free pin with no board drive and no pull-up toggles every cycle.
`timescale 1ns/1ps
`default_nettype none
module bsp_pins_model
(
  input wire logic clk_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] pullup_o,
  input wire logic [7:0] ext_i,
  input wire logic ext_en_i,
  output logic [7:0] pin_i
);
  logic flt_r = 1'b0;
  // A stale level must never read back as valid.
  always @(posedge clk_i) flt_r <= ~flt_r;
  // The port wins, then the board, then the pull-up.
  always_comb
    for (int i = 0; i < 8; i++)
      pin_i[i] = pin_oe_o[i] ? pin_o[i] : ext_en_i ? ext_i[i] : pullup_o[i] ? 1'b1 : flt_r;
endmodule
`default_nettype wire

// File: testbench/bsp_port_assertions.sv
// Purpose: Port-level checks of the eight-pin port.
// Assumes: Bound to every bsp_port.
// Notes: Sees top-level ports only.
`timescale 1ns/1ps
`default_nettype none
module bsp_port_checker
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic [7:0] segment_drive_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] pullup_o,
  input wire logic [7:0] digital_ok_o
);
  logic [7:0] seg_pin;
  // Segment level per pin; the map is not in bit order.
  assign seg_pin = {segment_drive_i[4], segment_drive_i[5], segment_drive_i[6], segment_drive_i[7],
    segment_drive_i[3:1], 1'b0};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_ack_next: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
    else $error("no answer in one cycle");
  a_dat_high: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_seg_level: assert property (((pin_o ^ seg_pin) & ~digital_ok_o) == 8'h00)
    else $error("segment level wrong");
  a_seg_drive: assert property ((pin_oe_o | digital_ok_o) == 8'hff)
    else $error("segment pin not driven");
  a_seg_nopull: assert property ((pullup_o & ~digital_ok_o) == 8'h00)
    else $error("segment pin pulled up");
  a_pull_dir: assert property ((pullup_o & pin_oe_o) == 8'h00)
    else $error("pull-up on driven pin");
  a_pin0_plain: assert property (digital_ok_o[0])
    else $error("pin zero left port mode");
  a_reset_quiet: assert property ($fell(rst_i) |-> pin_oe_o == 8'h00 && pullup_o == 8'h00)
    else $error("pins not idle after reset");
  c_err: cover property (err_o);
  c_seg: cover property (digital_ok_o != 8'hff);
  c_pull: cover property (pullup_o != 8'h00);
endmodule
bind bsp_port bsp_port_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .segment_drive_i(segment_drive_i), .pin_o(pin_o),
  .pin_oe_o(pin_oe_o), .pullup_o(pullup_o), .digital_ok_o(digital_ok_o));
`default_nettype wire

// File: testbench/bsp_port_tb.sv
// Purpose: Register and pin tests of the eight-pin port.
// Assumes: Classic Wishbone master, 20 MHz clock.
// Notes: Byte lane 0 is always selected.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module bsp_port_tb;
  import bsp_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ext_en = 1, ack_o, err_o, e;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat_w = 32'h0, dat_o, rd;
  logic [7:0] seg = 8'h5a, ext = 8'h3c, pin_i, pin_o, pin_oe_o, pullup_o, ok;
  logic [7:0] st [3] = '{8'h01, 8'h0e, 8'hf0};
  logic [7:0] ok_tab [3] = '{8'hff, 8'hf1, 8'h0f};
  int failures = 0, check_count = 0;
  // Clock of 50 ns period.
  initial forever #25 clk_i = ~clk_i;
  bsp_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'h1), .dat_i(dat_w), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .segment_drive_i(seg),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_o(pullup_o), .digital_ok_o(ok));
  bsp_pins_model i_pins (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_o(pullup_o),
    .ext_i(ext), .ext_en_i(ext_en), .pin_i(pin_i));
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One classic cycle; held until the answer is sampled.
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
    rd = dat_o;
    e = err_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk_rd(input string n, input logic [4:0] a, input logic [7:0] x);
    bus(a, 1'b0, 8'h00);
    `CHK(n, {24'h0, x}, rd)
  endtask
  // A hang ends the run as a failure.
  initial
  begin
    #100us;
    failures++;
    report_and_stop();
  end
  // Main sequence.
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_rd("dir", BSP_OFF_DIRECTION, 8'hff);
    chk_rd("pad", BSP_OFF_PAD_CFG, 8'h00);
    `CHK("oe", 8'h00, pin_oe_o)
    bus(BSP_OFF_DIRECTION, 1'b1, 8'hcf);
    bus(BSP_OFF_PIN_LEVEL, 1'b1, 8'h5a);
    chk_rd("latch", BSP_OFF_OUT_LATCH, 8'h5a);
    `CHK("oe", 8'h30, pin_oe_o)
    `CHK("drive", 8'h10, pin_o & 8'h30)
    chk_rd("level", BSP_OFF_PIN_LEVEL, 8'h1c);
    bus(BSP_OFF_PAD_CFG, 1'b1, 8'hff);
    chk_rd("pad", BSP_OFF_PAD_CFG, 8'he6);
    `CHK("pull", 8'hcf, pullup_o)
    ext_en <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk_rd("pulled", BSP_OFF_PIN_LEVEL, 8'hdf);
    bus(BSP_OFF_PAD_CFG, 1'b1, 8'h00);
    `CHK("pull", 8'h00, pullup_o)
    ext_en <= 1'b1;
    ext <= 8'hc3;
    repeat (3) @(posedge clk_i);
    chk_rd("level", BSP_OFF_PIN_LEVEL, 8'hd3);
    for (int i = 0; i < 3; i++)
    begin
      seg <= ~seg;
      bus(BSP_OFF_SEG_EN, 1'b1, st[i]);
      `CHK("digital", ok_tab[i], ok)
    end
    bus(5'h14, 1'b0, 8'h00);
    `CHK("err", 1'b1, e)
    report_and_stop();
  end
endmodule
`default_nettype wire
